// ---- rtl/exp_seq_consts.vh ----
// Constants for the expansion bus phase sequencer
`ifndef EXP_SEQ_CONSTS_VH
`define EXP_SEQ_CONSTS_VH

// Sequencer state codes
`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_SETUP 3'h2
`define ST_STROBE 3'h3
`define ST_HOLD 3'h4
`define ST_RECOV 3'h5

// Programmed phase field widths (field value N gives N+1 cycles, N+2 for host-port recovery)
`define ADDR_CNT_W 2
`define SETUP_CNT_W 2
`define STROBE_CNT_W 4
`define HOLD_CNT_W 2
`define RECOV_CNT_W 4

// Shared phase counter width, wide enough for recovery plus the host-port extra cycle
`define PHASE_CNT_W 5
`define PHASE_CNT_ZERO 5'h00
`define PHASE_CNT_ONE 5'h01

// Chip select numbering and the host-port ready group
`define CS_IDX_W 3
`define CS_NUM 8
`define CS_ALL_OFF 8'hff
`define CS_ONE_LOW 8'h01
`define RDY_NUM 4
`define RDY_IDX_W 2
`define RDY_FIRST_CS 3'h4

// Bus widths
`define ADDR_W 24
`define DATA_W 16

// Reset values
`define ADDR_RST 24'h000000
`define DATA_RST 16'h0000
`define RDY_RST 4'h0

`endif

// ---- rtl/input_sync3.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module input_sync3 #(
   parameter WIDTH = 4
) (
   input wire sys_clk_in,
   input wire rst_b_in,
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] level_out
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;

   // Stage one feeds only stage two; the output follows once stages two and three agree
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         level_out <= {WIDTH{1'b0}};
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level_out <= (stage2 & stage3) | (level_out & (stage2 ^ stage3));
      end
   end

endmodule // input_sync3

`default_nettype wire

// ---- rtl/exp_phase_seq.v ----
// Expansion bus five-phase access sequencer, strobe mode and host-port mode
`timescale 1ns/100ps
`default_nettype none
`include "exp_seq_consts.vh"

// How it works
// R1 - Strobe mode: address leads chip select by the programmed address phase, 1 to 4.
// R2 - Strobe mode writes: data leads falling strobe by programmed setup phase, 1 to 4.
// R3 - Strobe mode: data strobe stays low for programmed strobe phase, 1 to 16.
// R4 - After strobe rises, select, address and write data hold for 1 to 4 cycles.
// R5 - Strobe mode: idle recovery of 1 to 16 cycles between accesses.
// R6 - Non-multiplexed operation never pulses the address latch output.
// R7 - Data lines stay valid throughout the whole asserted strobe.
// R8 - Every phase counts whole cycles of the one bus clock.
// R9 - Host-port mode: software programs address phase count at least 2.
// R10 - Host-port mode: software programs setup phase count at least 2.
// R11 - Host-port mode: software programs strobe phase count at least 1.
// R12 - Asserted host wait holds the address or strobe phase until released.
// R13 - After host wait releases, address phase lasts one further clock.
// R14 - Host-port mode: address and chip select rise together, address held throughout.
// R15 - Host-port mode: first host strobe follows chip select after address plus setup.
// R16 - Host-port mode: first host strobe held asserted for the strobe phase.
// R17 - Host-port writes: data valid from setup phase until strobe rises.
// R18 - Host-port writes: data stays valid through the hold phase after strobe rises.
// R19 - Host-port mode: recovery lasts programmed count plus two, 2 to 17.
// R20 - Host-port mode: selects 4 to 7 each have a ready input 0 to 3 with programmable polarity.
// R21 - Phases run address, setup, strobe, hold, recovery, each counter loaded from its field.
module exp_phase_seq (
   input wire sys_clk_in,
   input wire rst_b_in,
   // Configuration
   input wire dsp_host_port_mode_in,
   input wire [`ADDR_CNT_W-1:0] address_phase_count_in,
   input wire [`SETUP_CNT_W-1:0] data_setup_phase_count_in,
   input wire [`STROBE_CNT_W-1:0] strobe_phase_count_in,
   input wire [`HOLD_CNT_W-1:0] hold_phase_count_in,
   input wire [`RECOV_CNT_W-1:0] recovery_phase_count_in,
   input wire [`RDY_NUM-1:0] ready_wait_high_in,
   // Internal master request
   input wire req_valid_in,
   input wire req_write_in,
   input wire [`CS_IDX_W-1:0] req_cs_in,
   input wire [`ADDR_W-1:0] req_addr_in,
   input wire [`DATA_W-1:0] req_wdata_in,
   output reg req_ready_out,
   output reg done_out,
   output reg [`DATA_W-1:0] rd_data_out,
   // Expansion bus pins
   input wire [`RDY_NUM-1:0] per_select_ready_input_in,
   input wire [`DATA_W-1:0] ex_data_in,
   output reg [`DATA_W-1:0] ex_data_out,
   output reg ex_data_oe_out,
   output reg [`ADDR_W-1:0] ex_addr_out,
   output reg [`CS_NUM-1:0] ex_cs_n_out,
   output reg ex_wr_n_out,
   output reg strobe_mode_data_strobe_n_out,
   output reg host_data_strobe_first_n_out,
   output reg address_latch_pulse_out
);

   // Sequencer state and phase counter
   reg [2:0] state;
   reg [2:0] next_state;
   reg [`PHASE_CNT_W-1:0] cnt;
   reg [`PHASE_CNT_W-1:0] next_cnt;
   // Extra address clock owed after a wait release
   reg addr_extend;
   reg next_addr_extend;

   // Access context captured when a request is taken
   reg acc_hpi;
   reg acc_write;
   reg [`CS_IDX_W-1:0] acc_cs;
   reg [`ADDR_W-1:0] acc_addr;
   reg [`DATA_W-1:0] acc_wdata;
   reg [`ADDR_CNT_W-1:0] acc_t_addr;
   reg [`SETUP_CNT_W-1:0] acc_t_setup;
   reg [`STROBE_CNT_W-1:0] acc_t_strobe;
   reg [`HOLD_CNT_W-1:0] acc_t_hold;
   reg [`RECOV_CNT_W-1:0] acc_t_recov;
   reg [`RDY_NUM-1:0] acc_rdy_pol;

   wire [`RDY_NUM-1:0] rdy_level;
   wire take_req;
   wire cnt_done;
   wire rdy_group;
   wire [`RDY_IDX_W-1:0] rdy_idx;
   wire host_wait;
   wire [`CS_IDX_W-1:0] rdy_offset;

   // Ready pins come from the host's clock domain, so they are filtered before use
   input_sync3 #(
      .WIDTH(`RDY_NUM)
   ) u_rdy_sync (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .pin_in(per_select_ready_input_in),
      .level_out(rdy_level)
   );

   // Select 4 maps to ready 0 up to select 7 on ready 3, each with its own polarity
   assign rdy_offset = acc_cs - `RDY_FIRST_CS;
   assign rdy_group = acc_hpi & acc_cs[`CS_IDX_W-1]; // R20
   assign rdy_idx = rdy_offset[`RDY_IDX_W-1:0]; // R20
   assign host_wait = rdy_group & (rdy_level[rdy_idx] == acc_rdy_pol[rdy_idx]); // R20

   assign take_req = req_valid_in & (state == `ST_IDLE);
   assign cnt_done = (cnt == `PHASE_CNT_ZERO); // R8

   // Next-state logic: each phase lasts its field value plus one bus clock, host-port recovery plus two
   always @* begin
      next_state = state;
      next_cnt = cnt;
      next_addr_extend = addr_extend;
      case (state)
         `ST_IDLE: begin
            next_addr_extend = 1'b0;
            if (req_valid_in) begin
               next_state = `ST_ADDR; // R21
               next_cnt = {{(`PHASE_CNT_W-`ADDR_CNT_W){1'b0}}, address_phase_count_in}; // R1
            end
         end
         `ST_ADDR: begin
            if (host_wait) begin
               // Hold the address while the host stalls, and owe one clock after release
               next_addr_extend = 1'b1; // R12
               if (!cnt_done) begin
                  next_cnt = cnt - `PHASE_CNT_ONE;
               end
            end else if (!cnt_done) begin
               next_cnt = cnt - `PHASE_CNT_ONE; // R1
            end else if (addr_extend) begin
               next_addr_extend = 1'b0; // R13
            end else begin
               next_state = `ST_SETUP; // R21
               next_cnt = {{(`PHASE_CNT_W-`SETUP_CNT_W){1'b0}}, acc_t_setup}; // R2
            end
         end
         `ST_SETUP: begin
            if (!cnt_done) begin
               next_cnt = cnt - `PHASE_CNT_ONE; // R2
            end else begin
               next_state = `ST_STROBE; // R21
               next_cnt = {{(`PHASE_CNT_W-`STROBE_CNT_W){1'b0}}, acc_t_strobe}; // R3
            end
         end
         `ST_STROBE: begin
            if (!cnt_done) begin
               next_cnt = cnt - `PHASE_CNT_ONE; // R3
            end else if (!host_wait) begin
               next_state = `ST_HOLD; // R12
               next_cnt = {{(`PHASE_CNT_W-`HOLD_CNT_W){1'b0}}, acc_t_hold}; // R4
            end
         end
         `ST_HOLD: begin
            if (!cnt_done) begin
               next_cnt = cnt - `PHASE_CNT_ONE; // R4
            end else begin
               next_state = `ST_RECOV; // R21
               // Host-port recovery is one clock longer than the strobe mode figure
               if (acc_hpi) begin
                  next_cnt = {{(`PHASE_CNT_W-`RECOV_CNT_W){1'b0}}, acc_t_recov}
                     + `PHASE_CNT_ONE; // R19
               end else begin
                  next_cnt = {{(`PHASE_CNT_W-`RECOV_CNT_W){1'b0}}, acc_t_recov}; // R5
               end
            end
         end
         `ST_RECOV: begin
            if (!cnt_done) begin
               next_cnt = cnt - `PHASE_CNT_ONE; // R5
            end else begin
               next_state = `ST_IDLE;
            end
         end
         default: begin
            next_state = `ST_IDLE;
            next_cnt = `PHASE_CNT_ZERO;
            next_addr_extend = 1'b0;
         end
      endcase
   end

   // State, counter and extension flag
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= `ST_IDLE;
         cnt <= `PHASE_CNT_ZERO;
         addr_extend <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         addr_extend <= next_addr_extend;
      end
   end

   // Capture the request and a snapshot of the timing fields, so a mid-access
   // reprogramming cannot stretch or cut a phase already under way
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         acc_hpi <= 1'b0;
         acc_write <= 1'b0;
         acc_cs <= {`CS_IDX_W{1'b0}};
         acc_addr <= `ADDR_RST;
         acc_wdata <= `DATA_RST;
         acc_t_addr <= {`ADDR_CNT_W{1'b0}};
         acc_t_setup <= {`SETUP_CNT_W{1'b0}};
         acc_t_strobe <= {`STROBE_CNT_W{1'b0}};
         acc_t_hold <= {`HOLD_CNT_W{1'b0}};
         acc_t_recov <= {`RECOV_CNT_W{1'b0}};
         acc_rdy_pol <= `RDY_RST;
      end else if (take_req) begin
         acc_hpi <= dsp_host_port_mode_in;
         acc_write <= req_write_in;
         acc_cs <= req_cs_in;
         acc_addr <= req_addr_in;
         acc_wdata <= req_wdata_in;
         acc_t_addr <= address_phase_count_in;
         acc_t_setup <= data_setup_phase_count_in;
         acc_t_strobe <= strobe_phase_count_in;
         acc_t_hold <= hold_phase_count_in;
         acc_t_recov <= recovery_phase_count_in;
         acc_rdy_pol <= ready_wait_high_in;
      end
   end

   // Pin decode from the next state so every pin changes on the phase edge itself
   wire nx_addr = (next_state == `ST_ADDR);
   wire nx_setup = (next_state == `ST_SETUP);
   wire nx_strobe = (next_state == `ST_STROBE);
   wire nx_hold = (next_state == `ST_HOLD);
   wire nx_active = nx_addr | nx_setup | nx_strobe | nx_hold;
   wire nx_hpi = take_req ? dsp_host_port_mode_in : acc_hpi;
   wire nx_write = take_req ? req_write_in : acc_write;
   wire [`CS_IDX_W-1:0] nx_cs = take_req ? req_cs_in : acc_cs;
   wire [`ADDR_W-1:0] nx_addr_val = take_req ? req_addr_in : acc_addr;
   wire [`CS_NUM-1:0] cs_onehot = `CS_ONE_LOW << nx_cs;
   // Strobe mode raises select after the address phase; host-port mode with the address
   wire nx_cs_on = nx_hpi ? nx_active : (nx_setup | nx_strobe | nx_hold); // R1 R15
   wire nx_drive = nx_write & (nx_setup | nx_strobe | nx_hold); // R2

   // Registered pin drivers
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ex_addr_out <= `ADDR_RST;
         ex_cs_n_out <= `CS_ALL_OFF;
         ex_wr_n_out <= 1'b1;
         ex_data_out <= `DATA_RST;
         ex_data_oe_out <= 1'b0;
         strobe_mode_data_strobe_n_out <= 1'b1;
         host_data_strobe_first_n_out <= 1'b1;
         address_latch_pulse_out <= 1'b0;
      end else begin
         // Address held from the address phase through hold in both modes
         if (nx_active) begin
            ex_addr_out <= nx_addr_val; // R14
         end
         ex_cs_n_out <= nx_cs_on ? ~cs_onehot : `CS_ALL_OFF; // R14
         ex_wr_n_out <= ~(nx_active & nx_write);
         // Write data driven from setup until hold ends, covering the whole strobe
         ex_data_out <= nx_drive ? acc_wdata_or_req(take_req) : ex_data_out; // R7
         ex_data_oe_out <= nx_drive; // R17 R18
         strobe_mode_data_strobe_n_out <= ~(nx_strobe & ~nx_hpi); // R3
         host_data_strobe_first_n_out <= ~(nx_strobe & nx_hpi); // R16
         // Only non-multiplexed modes exist here, so the latch pulse never fires
         address_latch_pulse_out <= 1'b0; // R6
      end
   end

   // Write data source; a request never reaches setup in its accept cycle
   function [`DATA_W-1:0] acc_wdata_or_req;
      input sel_req;
      begin
         acc_wdata_or_req = sel_req ? req_wdata_in : acc_wdata;
      end
   endfunction

   // Master handshake: ready only in idle, done pulses as recovery ends
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_ready_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         req_ready_out <= (next_state == `ST_IDLE);
         done_out <= (state == `ST_RECOV) & cnt_done;
      end
   end

   // Read data taken in the last strobe clock; the partner has had the whole
   // strobe to settle, and the bus is synchronous to this clock
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out <= `DATA_RST;
      end else if ((state == `ST_STROBE) & (next_state == `ST_HOLD) & ~acc_write) begin
         rd_data_out <= ex_data_in; // R7
      end
   end

   // Host-port timing floors fall to software; the fields are used as given
   // so that a short setting shows up as short timing, not a silent fix-up.
   // Address phase count at least 2 for host-port work. R9
   // Setup phase count at least 2 for host-port work. R10
   // Strobe phase count at least 1 for host-port work. R11
   // With those floors the first host strobe trails select by address plus
   // setup clocks and write data leads its rising edge by setup plus strobe. R15 R17

endmodule // exp_phase_seq

`default_nettype wire

// ---- test/exp_phase_seq_properties.sv ----
// Concurrent checks on the expansion bus phase sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "exp_seq_consts.vh"
module exp_phase_seq_properties (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic dsp_host_port_mode_in,
   input wire logic [`STROBE_CNT_W-1:0] strobe_phase_count_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic done_out,
   input wire logic [`DATA_W-1:0] ex_data_out,
   input wire logic ex_data_oe_out,
   input wire logic [`ADDR_W-1:0] ex_addr_out,
   input wire logic [`CS_NUM-1:0] ex_cs_n_out,
   input wire logic ex_wr_n_out,
   input wire logic strobe_mode_data_strobe_n_out,
   input wire logic host_data_strobe_first_n_out,
   input wire logic address_latch_pulse_out
);
   logic [4:0] low_cnt;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // Strobe-low length, kept by hand since the width reaches 16 cycles
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         low_cnt <= 5'h00;
      else if (strobe_mode_data_strobe_n_out)
         low_cnt <= 5'h00;
      else
         low_cnt <= low_cnt + 5'h01;
   end
   AST_NO_LATCH: assert property (!address_latch_pulse_out)
      else $error("address latch pulse seen");
   AST_DATA_STEADY: assert property (!strobe_mode_data_strobe_n_out
      && !$past(strobe_mode_data_strobe_n_out) |-> $stable(ex_data_out))
      else $error("data moved under strobe");
   AST_HDATA_STEADY: assert property (!host_data_strobe_first_n_out
      && !$past(host_data_strobe_first_n_out) |-> $stable(ex_data_out))
      else $error("data moved under host strobe");
   AST_STROBE_WIDTH: assert property ($rose(strobe_mode_data_strobe_n_out)
      && !dsp_host_port_mode_in |-> low_cnt == {1'b0, strobe_phase_count_in} + 5'h01)
      else $error("strobe width differs from field");
   AST_DONE_PULSE: assert property (done_out |=> !done_out)
      else $error("done longer than one cycle");
   AST_READY_AT_DONE: assert property (done_out |-> req_ready_out)
      else $error("not ready at done");
   AST_TAKE_BUSY: assert property (req_valid_in && req_ready_out |=> !req_ready_out[*5])
      else $error("ready back too soon");
   AST_CS_ONEHOT: assert property ($onehot0(~ex_cs_n_out))
      else $error("more than one select");
   AST_STROBE_IN_CS: assert property (!strobe_mode_data_strobe_n_out
      |-> $onehot(~ex_cs_n_out) && host_data_strobe_first_n_out)
      else $error("strobe outside select");
   AST_ADDR_HELD: assert property ($past(ex_cs_n_out) == ex_cs_n_out && !(&ex_cs_n_out)
      |-> $stable(ex_addr_out) && $stable(ex_wr_n_out))
      else $error("address moved under select");
   AST_WR_DRIVEN: assert property (!strobe_mode_data_strobe_n_out && !ex_wr_n_out
      |-> ex_data_oe_out)
      else $error("write data not driven");
endmodule // exp_phase_seq_properties
bind exp_phase_seq exp_phase_seq_properties i_exp_phase_seq_properties (
   .sys_clk_in(sys_clk_in),
   .rst_b_in(rst_b_in),
   .dsp_host_port_mode_in(dsp_host_port_mode_in),
   .strobe_phase_count_in(strobe_phase_count_in),
   .req_valid_in(req_valid_in),
   .req_ready_out(req_ready_out),
   .done_out(done_out),
   .ex_data_out(ex_data_out),
   .ex_data_oe_out(ex_data_oe_out),
   .ex_addr_out(ex_addr_out),
   .ex_cs_n_out(ex_cs_n_out),
   .ex_wr_n_out(ex_wr_n_out),
   .strobe_mode_data_strobe_n_out(strobe_mode_data_strobe_n_out),
   .host_data_strobe_first_n_out(host_data_strobe_first_n_out),
   .address_latch_pulse_out(address_latch_pulse_out)
);
`default_nettype wire

// ---- test/exp_periph_model.sv ----
// Peripheral and host-port model on the far side of the expansion bus
`timescale 1ns/100ps
`default_nettype none
module exp_periph_model (
   input wire logic clk_in,
   input wire logic [7:0] cs_n_in,
   input wire logic [23:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_n_in,
   input wire logic ds_n_in,
   input wire logic hds_n_in,
   input wire logic [3:0] stall_in,
   output logic [3:0] rdy_out,
   output logic [15:0] rdata_out,
   output logic [15:0] last_wr_out
);
   // Host ready pins, pin i for select 4+i; a host may raise its pin before the
   // access starts, so the pin is not gated by the select
   assign rdy_out = stall_in;
   // Released bus toggles so a stale word never passes as read data
   always @(posedge clk_in) begin
      if (!(&cs_n_in) && wr_n_in)
         rdata_out <= addr_in[15:0] ^ 16'h5a5a;
      else
         rdata_out <= ~rdata_out;
      if ((!ds_n_in || !hds_n_in) && !wr_n_in)
         last_wr_out <= wdata_in;
   end
endmodule // exp_periph_model
`default_nettype wire

// ---- test/exp_phase_seq_bench.sv ----
// Self-checking bench for the expansion bus phase sequencer
`timescale 1ns/100ps
`default_nettype none
module exp_phase_seq_bench;
   logic clk, rst_b, mode, valid, wr, ready, done, oe, wr_n, ds_n, hds_n, ale;
   logic [1:0] fa, fs, fh;
   logic [3:0] ft, fr, pol, rdy, stall;
   logic [2:0] cs;
   logic [23:0] addr, a_out;
   logic [15:0] wd, rd_in, rd_out, dout, last_wr;
   logic [7:0] cs_n;
   int errors, n_tests, c_pre, c_cs, c_st, c_hd, c_rc, c_ad;
   exp_phase_seq i_exp_phase_seq (.sys_clk_in(clk), .rst_b_in(rst_b),
      .dsp_host_port_mode_in(mode), .address_phase_count_in(fa),
      .data_setup_phase_count_in(fs), .strobe_phase_count_in(ft),
      .hold_phase_count_in(fh), .recovery_phase_count_in(fr), .ready_wait_high_in(pol),
      .req_valid_in(valid), .req_write_in(wr), .req_cs_in(cs), .req_addr_in(addr),
      .req_wdata_in(wd), .req_ready_out(ready), .done_out(done), .rd_data_out(rd_out),
      .per_select_ready_input_in(rdy), .ex_data_in(rd_in), .ex_data_out(dout),
      .ex_data_oe_out(oe), .ex_addr_out(a_out), .ex_cs_n_out(cs_n), .ex_wr_n_out(wr_n),
      .strobe_mode_data_strobe_n_out(ds_n), .host_data_strobe_first_n_out(hds_n),
      .address_latch_pulse_out(ale));
   exp_periph_model i_exp_periph_model (.clk_in(clk), .cs_n_in(cs_n), .addr_in(a_out),
      .wdata_in(dout), .wr_n_in(wr_n), .ds_n_in(ds_n), .hds_n_in(hds_n),
      .stall_in(stall), .rdy_out(rdy), .rdata_out(rd_in), .last_wr_out(last_wr));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic wrap_up;
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // One access, phases counted cycle by cycle; caller stands just after an edge
   task automatic run(input logic m, w, input logic [2:0] c, input logic [1:0] a, s,
         input logic [3:0] t, input logic [1:0] h, input logic [3:0] r, input logic stl);
      int k;
      int c_bad;
      logic sn;
      mode = m; wr = w; cs = c; fa = a; fs = s; ft = t; fh = h; fr = r;
      addr = addr + 24'h012345;
      wd = wd + 16'h1357;
      valid = 1'b1;
      sn = 1'b0; c_pre = 0; c_cs = 0; c_st = 0; c_hd = 0; c_rc = 0; c_ad = 0;
      c_bad = 0;
      // Ready is looked at once settled; the edge after it is seen takes the request
      for (k = 0; k < 600 && ready !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 valid = 1'b0;
      for (k = 0; k < 600 && done !== 1'b1; k++) begin
         if (!(&cs_n)) c_ad++;
         if ((m && !ds_n) || (!m && !hds_n)) c_bad++;
         if (!ds_n || !hds_n) begin
            c_st++;
            sn = 1'b1;
         end else if (&cs_n) begin
            if (sn) c_rc++;
            else c_pre++;
         end else if (sn) c_hd++;
         else c_cs++;
         @(posedge clk);
         #1;
      end
      chk("done", 1, done);
      chk("addr lead", m ? 0 : a + 1, c_pre);
      if (stl) chk("wait span", 1, c_cs >= 21 && c_cs <= 34);
      else chk("setup", m ? a + s + 2 : s + 1, c_cs);
      chk("strobe", t + 1, c_st);
      chk("strobe pin", 0, c_bad);
      chk("hold", h + 1, c_hd);
      chk("recovery", r + 1 + m, c_rc);
      chk("data", w ? wd : addr[15:0] ^ 16'h5a5a, w ? last_wr : rd_out);
   endtask
   task automatic t_strobe;
      run(0, 1, 3'h1, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0, 0);
      run(0, 1, 3'h1, 2'h3, 2'h3, 4'hf, 2'h3, 4'hf, 0);
      run(0, 0, 3'h2, 2'h3, 2'h3, 4'hf, 2'h3, 4'hf, 0);
   endtask
   task automatic t_host;
      run(1, 1, 3'h4, 2'h2, 2'h2, 4'h1, 2'h2, 4'h0, 0);
      chk("addr span", 1, c_ad >= 11 && c_ad <= 45);
      run(1, 0, 3'h7, 2'h3, 2'h3, 4'hf, 2'h3, 4'hf, 0);
   endtask
   // Wait raised on ready pin 1 (select 5) before the take, dropped twenty cycles later
   task automatic t_wait;
      stall = 4'h2;
      fork
         begin
            repeat (20) @(posedge clk);
            #1 stall = 4'h0;
         end
      join_none
      run(1, 1, 3'h5, 2'h3, 2'h2, 4'h1, 2'h2, 4'h0, 1);
   endtask
   task automatic t_reset;
      valid = 1'b1;
      repeat (3) @(posedge clk);
      #1 valid = 1'b0;
      rst_b = 1'b0;
      #1 chk("select idle", 8'hff, cs_n);
      chk("ready in reset", 0, ready);
      @(posedge clk);
      #1 rst_b = 1'b1;
      @(posedge clk);
      #1 chk("ready after", 1, ready);
   endtask
   initial begin
      rst_b = 1'b0; valid = 1'b0; wr = 1'b0; mode = 1'b0; stall = 4'h0; pol = 4'hf;
      cs = 3'h0; addr = 24'h000000; wd = 16'h0000;
      fa = 2'h0; fs = 2'h0; ft = 4'h0; fh = 2'h0; fr = 4'h0; errors = 0; n_tests = 0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      @(posedge clk);
      #1;
      t_strobe;
      t_host;
      t_wait;
      t_reset;
      wrap_up;
   end
   // Whole run is a few hundred cycles; this span leaves wide margin
   initial begin
      #200000;
      errors++;
      wrap_up;
   end
endmodule // exp_phase_seq_bench
`default_nettype wire
